// ===== rtl/lcgts_defs.vh
// Register map and field layout of the gate term selection block.
// Included by the block's design file; definitions only.
`ifndef LCGTS_DEFS_VH
`define LCGTS_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LCGTS_OFF_GATE1_SEL 12'h000
`define LCGTS_OFF_GATE2_SEL 12'h004
`define LCGTS_OFF_GATE3_SEL 12'h008
`define LCGTS_OFF_SRC_SEL 12'h00C
`define LCGTS_OFF_GATE_INV 12'h010
`define LCGTS_OFF_STATUS 12'h014

// ----------------------------------------
// Field layout
// ----------------------------------------
`define LCGTS_SEL_W 8
`define LCGTS_SRC_W 6
`define LCGTS_NUM_SRC 64
`define LCGTS_INV_W 3
`define LCGTS_SEL_RESET 8'h00
`define LCGTS_SRC_RESET 24'h000000
`define LCGTS_INV_RESET 3'h0

`endif

// ===== rtl/lcgts_gate_term_select.v
// Gate 1..3 term selection matrix with APB register access.
// Assumes an APB master on pclk; signal sources arrive as async pins.
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lcgts_defs.vh"

module lcgts_gate_term_select (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Signal sources
    input wire [`LCGTS_NUM_SRC-1:0] src_in,
    // Power-on reset for the selection registers
    input wire por_n,
    // Gate outputs to the cell function
    output reg [2:0] gate_out,
    output reg [3:0] cell_data_in
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [`LCGTS_SEL_W-1:0] gate1_term_select;
reg [`LCGTS_SEL_W-1:0] gate2_term_select;
reg [`LCGTS_SEL_W-1:0] gate3_term_select;
reg [4*`LCGTS_SRC_W-1:0] data_source_select;
reg [`LCGTS_INV_W-1:0] gate_output_invert;
reg [`LCGTS_NUM_SRC-1:0] src_s1;
reg [`LCGTS_NUM_SRC-1:0] src_s2;
reg [`LCGTS_NUM_SRC-1:0] src_s3;
reg [`LCGTS_NUM_SRC-1:0] src_stable;

wire access = psel && penable;
wire wr = access && pwrite;
wire rd_ok = (paddr == `LCGTS_OFF_GATE1_SEL) || (paddr == `LCGTS_OFF_GATE2_SEL) ||
    (paddr == `LCGTS_OFF_GATE3_SEL) || (paddr == `LCGTS_OFF_SRC_SEL) ||
    (paddr == `LCGTS_OFF_GATE_INV) || (paddr == `LCGTS_OFF_STATUS);

// ----------------------------------------
// Term matrix: OR of selected true/inverted inputs
// ----------------------------------------
function gate_terms;
    input [7:0] sel;
    input [3:0] d;
    begin
        gate_terms = (sel[7] & d[3]) | (sel[5] & d[2]) | (sel[3] & d[1]) | (sel[1] & d[0]) |
            (sel[6] & ~d[3]) | (sel[4] & ~d[2]) | (sel[2] & ~d[1]) | (sel[0] & ~d[0]);
    end
endfunction

// ----------------------------------------
// Source selection
// ----------------------------------------
function pick_src;
    input [`LCGTS_NUM_SRC-1:0] s;
    input [`LCGTS_SRC_W-1:0] idx;
    begin
        pick_src = s[idx];
    end
endfunction

reg [3:0] next_cell_data_in;
reg [2:0] next_gate_out;
integer i;
integer j;

always @* begin
    for (i = 0; i < 4; i = i + 1) begin
        next_cell_data_in[i] = pick_src(src_stable, data_source_select[i*`LCGTS_SRC_W +: `LCGTS_SRC_W]);
    end
    next_gate_out[0] = gate_terms(gate1_term_select, next_cell_data_in) ^ gate_output_invert[0];
    next_gate_out[1] = gate_terms(gate2_term_select, next_cell_data_in) ^ gate_output_invert[1];
    next_gate_out[2] = gate_terms(gate3_term_select, next_cell_data_in) ^ gate_output_invert[2];
end

// ----------------------------------------
// Input synchronisers, change counts when stages 2 and 3 agree
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        src_s1 <= {`LCGTS_NUM_SRC{1'b0}};
        src_s2 <= {`LCGTS_NUM_SRC{1'b0}};
        src_s3 <= {`LCGTS_NUM_SRC{1'b0}};
        src_stable <= {`LCGTS_NUM_SRC{1'b0}};
        cell_data_in <= 4'h0;
        gate_out <= 3'h0;
    end else begin
        src_s1 <= src_in;
        src_s2 <= src_s1;
        src_s3 <= src_s2;
        for (j = 0; j < `LCGTS_NUM_SRC; j = j + 1) begin
            if (src_s2[j] == src_s3[j]) begin
                src_stable[j] <= src_s3[j];
            end
        end
        cell_data_in <= next_cell_data_in;
        gate_out <= next_gate_out;
    end
end

// ----------------------------------------
// Selection registers, cleared only by power-on reset
// ----------------------------------------
always @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
        gate1_term_select <= `LCGTS_SEL_RESET;
        gate2_term_select <= `LCGTS_SEL_RESET;
        gate3_term_select <= `LCGTS_SEL_RESET;
        data_source_select <= `LCGTS_SRC_RESET;
        gate_output_invert <= `LCGTS_INV_RESET;
    end else if (wr) begin
        case (paddr)
            `LCGTS_OFF_GATE1_SEL: gate1_term_select <= pwdata[7:0];
            `LCGTS_OFF_GATE2_SEL: gate2_term_select <= pwdata[7:0];
            `LCGTS_OFF_GATE3_SEL: gate3_term_select <= pwdata[7:0];
            `LCGTS_OFF_SRC_SEL: data_source_select <= pwdata[23:0];
            `LCGTS_OFF_GATE_INV: gate_output_invert <= pwdata[2:0];
            default: gate_output_invert <= gate_output_invert;
        endcase
    end
end

// ----------------------------------------
// APB answer: one wait-free access cycle
// ----------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else begin
        pready <= psel && !penable;
        pslverr <= psel && !penable && !rd_ok;
        prdata <= 32'h00000000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `LCGTS_OFF_GATE1_SEL: prdata <= {24'h000000, gate1_term_select};
                `LCGTS_OFF_GATE2_SEL: prdata <= {24'h000000, gate2_term_select};
                `LCGTS_OFF_GATE3_SEL: prdata <= {24'h000000, gate3_term_select};
                `LCGTS_OFF_SRC_SEL: prdata <= {8'h00, data_source_select};
                `LCGTS_OFF_GATE_INV: prdata <= {29'h00000000, gate_output_invert};
                `LCGTS_OFF_STATUS: prdata <= {25'h0000000, gate_out, cell_data_in};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
end

endmodule
`default_nettype wire

// ===== tb/lcgts_assertions.sv
// Bus checker for the gate term select block.
// Bound to the top module by the bench.
`timescale 1ns/1ps
`default_nettype none
module lcgts_assertions (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire setup = psel && !penable;
    a_ready_next: assert property (setup |=> pready && penable) else $error("late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long");
    a_ready_access: assert property (pready |-> psel && penable) else $error("stray");
    a_err_qual: assert property (pslverr |-> pready) else $error("err");
    a_err_unmapped: assert property (setup && paddr > 12'h014 |=> pslverr) else $error("unmapped");
    a_ok_mapped: assert property (setup && !pwrite && paddr[1:0] == 2'h0 && paddr <= 12'h014 |=> !pslverr) else $error("ok");
    a_err_data: assert property (pslverr |-> prdata == 32'h0) else $error("data");
    a_high_zero: assert property (pready && !pwrite |-> prdata[31:24] == 8'h0) else $error("high");
    c_wr: cover property (pready && pwrite);
    c_rd: cover property (pready && !pwrite);
    c_err: cover property (pslverr);
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Bench for the gate term select block.
// Drives APB and the sources itself.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0, e, pready, pslverr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic [63:0] src_in = 0;
    logic [2:0] gate_out;
    logic [3:0] cell_data_in;
    integer err_total = 0, check_count = 0, g, b, p, n;
    always #5 pclk = ~pclk;
    lcgts_gate_term_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_in(src_in),
        .por_n(por_n), .gate_out(gate_out), .cell_data_in(cell_data_in));
    task conclude;
        begin
            $display("checks %0d errors %0d", check_count, err_total);
            if (err_total == 0 && check_count > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input string nm, input logic [31:0] x, input logic [31:0] s);
        begin
            check_count++;
            if (s !== x) begin
                err_total++;
                $display("[FAIL] %s exp %h got %h", nm, x, s);
            end
        end
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        begin
            psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
            @(posedge pclk);
            penable <= 1;
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (pready !== 1'b1 && n < 20);
            if (pready !== 1'b1) begin
                err_total++;
                conclude;
            end
            r = prdata;
            e = pslverr;
            psel <= 0; penable <= 0;
            @(posedge pclk);
        end
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        por_n <= 1; presetn <= 1;
        @(posedge pclk);
        apb(12'h00C, 1'b1, 32'h000C2040);
        for (g = 0; g < 3; g++) begin
            for (b = 0; b < 9; b++) begin
                apb(12'(4 * g), 1'b1, (b < 8) ? 32'h1 << b : 32'h0);
                apb(12'(4 * g), 1'b0, 32'h0);
                chk("sel", (b < 8) ? 32'h1 << b : 32'h0, r);
                for (p = 0; p < 2; p++) begin
                    src_in <= p ? 64'hA : 64'h5;
                    repeat (8) @(posedge pclk);
                    chk("data", src_in[3:0], cell_data_in);
                    chk("gate", (b < 8) && (src_in[b >> 1] == b[0]), gate_out[g]);
                end
            end
        end
        $display("test done: term select");
        apb(12'h010, 1'b1, 32'h7);
        repeat (8) @(posedge pclk);
        chk("inv", 3'h7, gate_out);
        apb(12'h008, 1'b1, 32'hA5);
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(12'h008, 1'b0, 32'h0);
        chk("keep", 32'hA5, r);
        apb(12'h020, 1'b0, 32'h0);
        chk("err", 1'b1, e);
        $display("test done: bus");
        conclude;
    end
endmodule
bind lcgts_gate_term_select lcgts_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
